// File: verilog/grouped_irq_pkg.sv
package grouped_irq_pkg;

  // register byte offsets
  localparam logic [7:0] OFS_SUPPLY = 8'h00;
  localparam logic [7:0] OFS_ENABLE = 8'h04;
  localparam logic [7:0] OFS_FLAGS  = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;

  // low_voltage_detect_control fields
  localparam int SUP_SEL_LSB = 0;
  localparam int SUP_ON_BIT  = 4;
  localparam int SUP_DET_BIT = 5;
  localparam logic [2:0] SUP_SEL_RST = 3'h0;
  localparam logic       SUP_ON_RST  = 1'b0;

  // source numbering inside the flag and enable words
  localparam int NSRC      = 7;
  localparam int NGRP      = 4;
  localparam int SRC_SPB   = 0;
  localparam int SRC_LV    = 1;
  localparam int SRC_NVM   = 2;
  localparam int SRC_TM0A  = 3;
  localparam int SRC_TM0P  = 4;
  localparam int SRC_TM1A  = 5;
  localparam int SRC_TM1P  = 6;
  localparam int EN_GIE_BIT = 0;
  localparam int EN_SRC_LSB = 1;
  localparam int EN_GRP_LSB = 8;
  localparam int FL_GRP_LSB = 8;
  localparam logic [NSRC-1:0] SRC_EN_RST  = 7'h00;
  localparam logic [NGRP-1:0] GRP_EN_RST  = 4'h0;
  localparam logic [NSRC-1:0] SRC_FL_RST  = 7'h00;
  localparam logic [NGRP-1:0] GRP_FL_RST  = 4'h0;
  localparam logic            GIE_RST     = 1'b0;

  // which sources feed which group
  localparam logic [NSRC-1:0] GRP_MEMBERS [NGRP] = '{7'h18, 7'h60, 7'h06, 7'h01};

  // detection voltages in millivolts, per threshold code
  localparam logic [12:0] THRESH_MV [8] = '{13'd2000, 13'd2200, 13'd2400, 13'd2700,
                                            13'd3000, 13'd3300, 13'd3600, 13'd4000};

  // timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int SETTLE_DELAY_NS  = 15000;
  localparam int SETTLE_DELAY_CYC = (SETTLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W     = 10;

  typedef struct packed {
    logic [2:0]           sel;
    logic                 mon_on;
    logic                 cmp_s1;
    logic                 cmp_s2;
    logic [SETTLE_CNT_W-1:0] cnt;
    logic                 gie;
    logic [NSRC-1:0]      src_en;
    logic [NGRP-1:0]      grp_en;
    logic [NSRC-1:0]      src_fl;
    logic [NGRP-1:0]      grp_fl;
    logic [NSRC-1:0]      armed_prev;
    logic [NSRC+NGRP-1:0] fl_prev;
    logic                 wake;
    logic [31:0]          rdata;
    logic                 err;
  } irq_state_s;

  typedef struct packed {
    logic       spb_byte_done;
    logic       nvm_write_end;
    logic [1:0] tm_match_a;
    logic [1:0] tm_match_p;
  } src_events_s;

endpackage

// File: verilog/grouped_irq_and_supply_monitor.sv
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps

// Operation
// - serial port b byte done sets flag
// - vector needs all enables and stack room
// - service clears global enable, group flag
// - supply below threshold sets supply flag
// - nvm write end sets flag, own enable
// - timer A and P: own flags, enables
// - timer match flags raise request via group
// - low-power wake on any flag rising
// - enables gate service and group flag setting, source flags persist
// - entry pushes only program counter
// - return with reenable sets global enable
// - plain return leaves global enable unchanged
// - three-bit threshold select, bits 2:0
// - detect output bit 5, read-only
// - bit 4 switches monitor on
// - bits 7:6 and 3 read zero
// - codes map 2.0 to 4.0 volts
// - supply flag only after settling delay
// - group flag set when member flag sets while its source enable is set
module grouped_irq_and_supply_monitor
  import grouped_irq_pkg::*;
(
  // clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // peripheral sources
  input  wire src_events_s src_ev,
  input  wire logic        supply_cmp_low,
  output logic [2:0]       supply_threshold_select,
  output logic [12:0]      supply_threshold_mv,
  output logic             supply_monitor_on,
  // cpu core
  input  wire logic        stack_full,
  input  wire logic        irq_taken,
  input  wire logic        interrupt_exit_with_reenable,
  input  wire logic        subroutine_exit,
  input  wire logic        low_power_mode,
  output logic             irq_req,
  output logic [1:0]       irq_vector,
  output logic             pc_push,
  output logic             wake_up
);

  irq_state_s r_r;
  irq_state_s r_nxt;

  logic                 setup_phase;
  logic                 acc_phase;
  logic                 wr_supply;
  logic                 wr_en;
  logic                 wr_fl;
  logic                 detect;
  logic                 settled;
  logic [NSRC-1:0]      hw_set;
  logic [NSRC-1:0]      armed;
  logic [NSRC-1:0]      armed_rise;
  logic [NGRP-1:0]      grp_set;
  logic [NGRP-1:0]      grp_ready;
  logic                 take;
  logic [NSRC+NGRP-1:0] all_fl;
  logic [NSRC+NGRP-1:0] fl_rise;
  logic [31:0]          rd_word;
  logic                 rd_miss;

  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = addr_hit(a, OFS_SUPPLY) | addr_hit(a, OFS_ENABLE) |
             addr_hit(a, OFS_FLAGS) | addr_hit(a, OFS_STATUS);
  endfunction

  // one bit per source, in the order of the flag word
  function automatic logic [NSRC-1:0] event_bits(input src_events_s ev, input logic lv_hit);
    event_bits           = '0;
    event_bits[SRC_SPB]  = ev.spb_byte_done;
    event_bits[SRC_LV]   = lv_hit;
    event_bits[SRC_NVM]  = ev.nvm_write_end;
    event_bits[SRC_TM0A] = ev.tm_match_a[0];
    event_bits[SRC_TM0P] = ev.tm_match_p[0];
    event_bits[SRC_TM1A] = ev.tm_match_a[1];
    event_bits[SRC_TM1P] = ev.tm_match_p[1];
  endfunction

  function automatic logic [1:0] first_set(input logic [NGRP-1:0] v);
    first_set = 2'h0;
    for (int i = NGRP - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 2'(i);
      end
    end
  endfunction

  // zero wait states: every access phase completes at once
  assign pready      = 1'b1;
  assign prdata      = r_r.rdata;
  assign setup_phase = psel & ~penable;
  assign acc_phase   = psel & penable;
  assign pslverr     = r_r.err & acc_phase;

  // writes land only while the clock enable runs
  assign wr_supply = ce & acc_phase & pwrite & addr_hit(paddr, OFS_SUPPLY);
  assign wr_en     = ce & acc_phase & pwrite & addr_hit(paddr, OFS_ENABLE);
  assign wr_fl     = ce & acc_phase & pwrite & addr_hit(paddr, OFS_FLAGS);

  // read mux; reserved bits and unmapped words read zero
  always_comb begin
    rd_word = '0;
    if (addr_hit(paddr, OFS_SUPPLY)) begin
      rd_word[SUP_SEL_LSB +: 3] = r_r.sel;
      rd_word[SUP_ON_BIT]       = r_r.mon_on;
      rd_word[SUP_DET_BIT]      = detect;
    end
    if (addr_hit(paddr, OFS_ENABLE)) begin
      rd_word[EN_GIE_BIT]         = r_r.gie;
      rd_word[EN_SRC_LSB +: NSRC] = r_r.src_en;
      rd_word[EN_GRP_LSB +: NGRP] = r_r.grp_en;
    end
    if (addr_hit(paddr, OFS_FLAGS)) begin
      rd_word[NSRC-1:0]           = r_r.src_fl;
      rd_word[FL_GRP_LSB +: NGRP] = r_r.grp_fl;
    end
    if (addr_hit(paddr, OFS_STATUS)) begin
      rd_word[0]   = irq_req;
      rd_word[2:1] = irq_vector;
      rd_word[3]   = r_r.cmp_s2;
    end
  end

  assign rd_miss = ~mapped(paddr);

  // comparator output only trusted while monitor is on
  assign detect  = r_r.mon_on & r_r.cmp_s2;
  // one set per episode: the counter parks one past the delay
  assign settled = detect & (r_r.cnt == SETTLE_CNT_W'(SETTLE_DELAY_CYC));

  assign supply_threshold_select = r_r.sel;
  assign supply_threshold_mv     = THRESH_MV[r_r.sel];
  assign supply_monitor_on       = r_r.mon_on;

  // hardware set events per source
  assign hw_set = event_bits(src_ev, settled);

  // a source counts toward its group only while its own enable is set
  assign armed      = r_r.src_fl & r_r.src_en;
  assign armed_rise = armed & ~r_r.armed_prev;

  genvar g;
  generate
    for (g = 0; g < NGRP; g++) begin : grp_gen
      assign grp_set[g]   = |(armed_rise & GRP_MEMBERS[g]);
      assign grp_ready[g] = r_r.grp_fl[g] & r_r.grp_en[g];
    end
  endgenerate

  assign irq_req    = r_r.gie & ~stack_full & (|grp_ready);
  assign irq_vector = first_set(grp_ready);
  assign take       = irq_req & irq_taken;
  // only the program counter is saved, never working registers
  assign pc_push    = take;
  assign wake_up    = r_r.wake;

  assign all_fl = {r_r.grp_fl, r_r.src_fl};

  // per-flag rise detect; enables play no part in wake
  genvar f;
  generate
    for (f = 0; f < NSRC + NGRP; f++) begin : rise_gen
      assign fl_rise[f] = all_fl[f] & ~r_r.fl_prev[f];
    end
  endgenerate

  always_comb begin
    r_nxt = r_r;

    // two-stage synchroniser for the analog comparator
    r_nxt.cmp_s1 = supply_cmp_low;
    r_nxt.cmp_s2 = r_r.cmp_s1;

    // settling counter restarts whenever detection drops
    if (!detect) begin
      r_nxt.cnt = '0;
    end else if (r_r.cnt != SETTLE_CNT_W'(SETTLE_DELAY_CYC + 1)) begin
      r_nxt.cnt = r_r.cnt + SETTLE_CNT_W'(1);
    end

    // register writes
    if (wr_supply) begin
      r_nxt.sel    = pwdata[SUP_SEL_LSB +: 3];
      r_nxt.mon_on = pwdata[SUP_ON_BIT];
    end
    if (wr_en) begin
      r_nxt.gie    = pwdata[EN_GIE_BIT];
      r_nxt.src_en = pwdata[EN_SRC_LSB +: NSRC];
      r_nxt.grp_en = pwdata[EN_GRP_LSB +: NGRP];
    end

    // software may write flags either way; it may pre-set one to mute wake
    if (wr_fl) begin
      r_nxt.src_fl = pwdata[NSRC-1:0];
      r_nxt.grp_fl = pwdata[FL_GRP_LSB +: NGRP];
    end

    // service clears gie and the group flag, source flags stay set
    if (take) begin
      r_nxt.gie                = 1'b0;
      r_nxt.grp_fl[irq_vector] = 1'b0;
    end

    if (interrupt_exit_with_reenable) begin
      r_nxt.gie = 1'b1;
    end
    // subroutine_exit deliberately leaves gie untouched

    // hardware sets win over any same-cycle clear
    r_nxt.src_fl     = r_nxt.src_fl | hw_set;
    r_nxt.grp_fl     = r_nxt.grp_fl | grp_set;
    r_nxt.armed_prev = armed;

    // rising edge of any flag, enables ignored
    r_nxt.fl_prev = all_fl;
    r_nxt.wake    = low_power_mode & (|fl_rise);

    // read data captured in the setup phase
    r_nxt.err = 1'b0;
    if (setup_phase) begin
      r_nxt.rdata = rd_word;
      // unmapped word: slave error, write ignored
      r_nxt.err   = rd_miss;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_r.sel        <= SUP_SEL_RST;
      r_r.mon_on     <= SUP_ON_RST;
      r_r.cmp_s1     <= 1'b0;
      r_r.cmp_s2     <= 1'b0;
      r_r.cnt        <= '0;
      r_r.gie        <= GIE_RST;
      r_r.src_en     <= SRC_EN_RST;
      r_r.grp_en     <= GRP_EN_RST;
      r_r.src_fl     <= SRC_FL_RST;
      r_r.grp_fl     <= GRP_FL_RST;
      r_r.armed_prev <= '0;
      r_r.fl_prev    <= '0;
      r_r.wake       <= 1'b0;
      r_r.rdata      <= '0;
      r_r.err        <= 1'b0;
    end else if (ce) begin
      r_r <= r_nxt;
    end
  end

endmodule

// File: testbench/grouped_irq_props.sv
`timescale 1ns/1ps
module grouped_irq_props (
  // clock, reset
  input wire logic        pclk,
  input wire logic        presetn,
  // core side
  input wire logic        stack_full,
  input wire logic        irq_taken,
  input wire logic        interrupt_exit_with_reenable,
  input wire logic        low_power_mode,
  input wire logic        irq_req,
  input wire logic        pc_push,
  input wire logic        wake_up,
  // supply monitor
  input wire logic [2:0]  supply_threshold_select,
  input wire logic [12:0] supply_threshold_mv
);
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_req_gate: assert property (irq_req |-> !stack_full)
    else $error("request while stack full");
  a_push_pair: assert property (pc_push == (irq_req && irq_taken))
    else $error("push not tied to take");
  a_take_clear: assert property ((pc_push && !interrupt_exit_with_reenable) |=> !irq_req)
    else $error("request kept after service");
  a_ret_keep: assert property ((pc_push && !interrupt_exit_with_reenable) ##1
    (!interrupt_exit_with_reenable)[*3] |-> !irq_req) else $error("request back without reenable");
  a_wake_mode: assert property (wake_up |-> $past(low_power_mode))
    else $error("wake outside low power");
  a_mv_low: assert property (supply_threshold_select == 3'h0 |-> supply_threshold_mv == 13'd2000)
    else $error("code 0 level");
  a_mv_mid: assert property (supply_threshold_select == 3'h3 |-> supply_threshold_mv == 13'd2700)
    else $error("code 3 level");
  a_mv_high: assert property (supply_threshold_select == 3'h7 |-> supply_threshold_mv == 13'd4000)
    else $error("code 7 level");
endmodule
bind grouped_irq_and_supply_monitor grouped_irq_props u_props (.*);

// File: testbench/cpu_model.sv
`timescale 1ns/1ps
module cpu_model (
  // clock, reset
  input wire logic  pclk,
  input wire logic  presetn,
  // control from bench
  input wire logic  ret_reenable,
  input wire logic [3:0] dly,
  // vectoring
  input wire logic  irq_req,
  output logic      irq_taken,
  output logic      interrupt_exit_with_reenable,
  output logic      subroutine_exit
);
  logic [3:0] wait_r;
  logic [2:0] isr_r;
  // takes only while not in a routine; saves nothing beyond the pushed pc
  assign irq_taken = irq_req && isr_r == 3'h0 && wait_r == dly;
  assign interrupt_exit_with_reenable = ret_reenable && isr_r == 3'h7;
  assign subroutine_exit = !ret_reenable && isr_r == 3'h7;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 4'h0;
      isr_r <= 3'h0;
    end else begin
      wait_r <= (irq_req && isr_r == 3'h0 && wait_r != dly) ? wait_r + 4'h1 : 4'h0;
      if (irq_taken || isr_r != 3'h0) isr_r <= isr_r + 3'h1;
    end
  end
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench import grouped_irq_pkg::*;;
  logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic        stack_full = 0, low_power_mode = 0, supply_cmp_low = 0, ret_reenable = 1;
  logic [3:0]  dly = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, rdv;
  src_events_s src_ev = '0;
  logic        pready, pslverr, errv, irq_req, pc_push, wake_up, irq_taken;
  logic        interrupt_exit_with_reenable, subroutine_exit, supply_monitor_on;
  logic [2:0]  supply_threshold_select;
  logic [12:0] supply_threshold_mv;
  logic [1:0]  irq_vector;
  int          n_errors = 0, checks = 0, n_push = 0, n_wake = 0, cyc = 0;
  grouped_irq_and_supply_monitor dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .src_ev(src_ev), .supply_cmp_low(supply_cmp_low),
    .supply_threshold_select(supply_threshold_select),
    .supply_threshold_mv(supply_threshold_mv), .supply_monitor_on(supply_monitor_on),
    .stack_full(stack_full), .irq_taken(irq_taken),
    .interrupt_exit_with_reenable(interrupt_exit_with_reenable),
    .subroutine_exit(subroutine_exit), .low_power_mode(low_power_mode),
    .irq_req(irq_req), .irq_vector(irq_vector), .pc_push(pc_push), .wake_up(wake_up));
  cpu_model core (
    .pclk(pclk), .presetn(presetn), .ret_reenable(ret_reenable), .dly(dly),
    .irq_req(irq_req), .irq_taken(irq_taken),
    .interrupt_exit_with_reenable(interrupt_exit_with_reenable),
    .subroutine_exit(subroutine_exit));
  initial forever #12.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    n_push += pc_push;
    n_wake += wake_up;
    if (cyc == 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // held until pready is seen; any number of wait states allowed
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdv = prdata;
    errv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // one idle edge so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask
  task pulse(input logic [5:0] e);
    src_ev <= e;
    @(posedge pclk) src_ev <= '0;
    tick(3);
  endtask
  task t_regs;
    apb(0, OFS_SUPPLY, 0);
    chk("supply reset", 0, rdv);
    for (int i = 0; i < 8; i++) begin
      apb(1, OFS_SUPPLY, 32'hC8 | i);
      apb(0, OFS_SUPPLY, 0);
      chk("supply sel", i, rdv);
      chk("sel out", i, supply_threshold_select);
      chk("mv", THRESH_MV[i], supply_threshold_mv);
    end
    apb(0, 8'h10, 0);
    chk("unmapped", 1, errv);
    $display("t_regs done");
  endtask
  task t_spb;
    apb(1, OFS_ENABLE, 32'h803);
    stack_full <= 1'h1;
    pulse(6'h20);
    chk("req blocked", 0, irq_req);
    chk("vector", 3, irq_vector);
    apb(0, OFS_STATUS, 0);
    chk("status", 32'h6, rdv);
    apb(0, OFS_FLAGS, 0);
    chk("spb flags", 32'h801, rdv);
    stack_full <= 1'h0;
    tick(12);
    chk("push", 1, n_push);
    apb(0, OFS_FLAGS, 0);
    chk("kept src", 32'h001, rdv);
    apb(0, OFS_ENABLE, 0);
    chk("interrupt_exit_with_reenable gie", 32'h803, rdv);
    $display("t_spb done");
  endtask
  task t_ret;
    ret_reenable <= 1'h0;
    dly <= 4'h3;
    apb(1, OFS_FLAGS, 0);
    apb(1, OFS_ENABLE, 32'h409);
    pulse(6'h10);
    tick(14);
    chk("push", 2, n_push);
    apb(0, OFS_ENABLE, 0);
    chk("ret gie", 32'h408, rdv);
    apb(1, OFS_ENABLE, 32'h688);
    pulse(6'h02);
    chk("no req", 0, irq_req);
    apb(1, OFS_ENABLE, 0);
    apb(0, OFS_FLAGS, 0);
    chk("flags", 32'h244, rdv);
    $display("t_ret done");
  endtask
  task t_lv;
    apb(1, OFS_FLAGS, 0);
    apb(1, OFS_SUPPLY, 32'h13);
    chk("mon on", 1, supply_monitor_on);
    supply_cmp_low <= 1'h1;
    tick(5);
    apb(0, OFS_SUPPLY, 0);
    chk("detect", 32'h33, rdv);
    tick(500);
    apb(0, OFS_FLAGS, 0);
    chk("lv early", 0, rdv);
    tick(150);
    apb(0, OFS_FLAGS, 0);
    chk("lv flag", 32'h002, rdv);
    supply_cmp_low <= 1'h0;
    $display("t_lv done");
  endtask
  task t_wake;
    int w0;
    apb(1, OFS_FLAGS, 0);
    low_power_mode <= 1'h1;
    w0 = n_wake;
    pulse(6'h10);
    chk("wake", w0 + 1, n_wake);
    pulse(6'h10);
    chk("no wake", w0 + 1, n_wake);
    low_power_mode <= 1'h0;
    $display("t_wake done");
  endtask
  task t_freeze;
    ce <= 1'h0;
    pulse(6'h08);
    ce <= 1'h1;
    apb(0, OFS_FLAGS, 0);
    chk("frozen flags", 32'h004, rdv);
    $display("t_freeze done");
  endtask
  initial begin
    tick(6);
    presetn <= 1'h1;
    tick(1);
    t_regs();
    t_spb();
    t_ret();
    t_lv();
    t_wake();
    t_freeze();
    end_of_test();
  end
endmodule
